// *** rtl/sfmf_pkg.sv ***
package sfmf_pkg;
	localparam int SFMF_ADDR_W = 18;
	localparam int SFMF_DATA_W = 8;
	localparam int SFMF_SYNC_W = 2;

	// Write port pins, sampled together
	typedef struct packed {
		logic rst;
		logic en;
		logic mask;
		logic [SFMF_DATA_W-1:0] data;
	} sfmf_wr_pins_t;

	// Read port pins, sampled together
	typedef struct packed {
		logic rst;
		logic en;
		logic oe;
	} sfmf_rd_pins_t;

	localparam sfmf_wr_pins_t SFMF_WR_PINS_IDLE = '0;
	localparam sfmf_rd_pins_t SFMF_RD_PINS_IDLE = '0;
	localparam logic [SFMF_DATA_W-1:0] SFMF_DATA_ZERO = 8'h00;
endpackage

// *** rtl/sfmf_pin_sync.sv ***
`timescale 1ns/10ps
// Brings one port clock and its companion pins into clk_i, flags clock rises
module sfmf_pin_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic port_clock_i,
	input wire logic [W-1:0] pins_i,
	output logic rise_o,
	output logic [W-1:0] pins_o
);
	import sfmf_pkg::*;

	logic ck_meta_r, ck_sync_r, ck_prev_r;
	logic ck_meta_nxt, ck_sync_nxt, ck_prev_nxt;
	logic [W-1:0] pin_meta_r, pin_sync_r, pin_prev_r;
	logic [W-1:0] pin_meta_nxt, pin_sync_nxt, pin_prev_nxt;
	logic rise_r, rise_nxt;

	// Two stages, then one more to match the registered rise, so pins come from the clock's first high sample
	always_comb begin
		ck_meta_nxt = port_clock_i;
		ck_sync_nxt = ck_meta_r;
		ck_prev_nxt = ck_sync_r;
		pin_meta_nxt = pins_i;
		pin_sync_nxt = pin_meta_r;
		pin_prev_nxt = pin_sync_r;
		rise_nxt = ck_sync_r & ~ck_prev_r;
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			ck_meta_r <= 1'b0;
			ck_sync_r <= 1'b0;
			ck_prev_r <= 1'b0;
			pin_meta_r <= '0;
			pin_sync_r <= '0;
			pin_prev_r <= '0;
			rise_r <= 1'b0;
		end else begin
			ck_meta_r <= ck_meta_nxt;
			ck_sync_r <= ck_sync_nxt;
			ck_prev_r <= ck_prev_nxt;
			pin_meta_r <= pin_meta_nxt;
			pin_sync_r <= pin_sync_nxt;
			pin_prev_r <= pin_prev_nxt;
			rise_r <= rise_nxt;
		end
	end

	assign rise_o = rise_r;
	// Pins as sampled on the same edge that first saw the port clock high
	assign pins_o = pin_prev_r;
endmodule

// *** rtl/sfmf_top.sv ***
`timescale 1ns/10ps
// Serial field memory used as a delay line between two pin-driven ports.
// Port clocks are oversampled by clk_i, so each must stay well under a
// quarter of the clk_i rate; a stopped port clock just means no edges.
module sfmf_top #(
	parameter int ADDR_W = sfmf_pkg::SFMF_ADDR_W
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic write_port_clock_i,
	input wire logic write_pointer_reset_i,
	input wire logic write_enable_i,
	input wire logic input_mask_i,
	input wire logic [sfmf_pkg::SFMF_DATA_W-1:0] write_data_bus_i,
	input wire logic read_port_clock_i,
	input wire logic read_pointer_reset_i,
	input wire logic read_advance_enable_i,
	input wire logic output_enable_i,
	output logic [sfmf_pkg::SFMF_DATA_W-1:0] read_data_bus_o,
	output logic read_data_bus_oe_o
);
	import sfmf_pkg::*;

	localparam int DEPTH = 1 << ADDR_W;
	localparam logic [ADDR_W-1:0] PTR_ZERO = '0;
	localparam logic [ADDR_W-1:0] PTR_ONE = {{(ADDR_W-1){1'b0}}, 1'b1};

	sfmf_wr_pins_t wr_pins_in, wr_pins;
	sfmf_rd_pins_t rd_pins_in, rd_pins;
	logic wr_rise, rd_rise;

	assign wr_pins_in.rst = write_pointer_reset_i;
	assign wr_pins_in.en = write_enable_i;
	assign wr_pins_in.mask = input_mask_i;
	assign wr_pins_in.data = write_data_bus_i;
	assign rd_pins_in.rst = read_pointer_reset_i;
	assign rd_pins_in.en = read_advance_enable_i;
	assign rd_pins_in.oe = output_enable_i;

	// Write port pins into the core clock
	sfmf_pin_sync #(
		.W($bits(sfmf_wr_pins_t))
	) u_wr_sync (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.port_clock_i(write_port_clock_i),
		.pins_i(wr_pins_in),
		.rise_o(wr_rise),
		.pins_o(wr_pins)
	);

	// Read port pins into the core clock
	sfmf_pin_sync #(
		.W($bits(sfmf_rd_pins_t))
	) u_rd_sync (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.port_clock_i(read_port_clock_i),
		.pins_i(rd_pins_in),
		.rise_o(rd_rise),
		.pins_o(rd_pins)
	);

	// Storage: plain flip-flops, so nothing ever needs refreshing
	logic [SFMF_DATA_W-1:0] mem_r [DEPTH];

	// Write side state: pointer plus a one-word serial stage
	logic [ADDR_W-1:0] wr_ptr_r, wr_ptr_nxt; // Spans the whole array
	logic stage_vld_r, stage_vld_nxt;
	logic [ADDR_W-1:0] stage_addr_r, stage_addr_nxt;
	logic [SFMF_DATA_W-1:0] stage_data_r, stage_data_nxt;
	logic commit;

	// Read side state
	logic [ADDR_W-1:0] rd_ptr_r, rd_ptr_nxt; // Spans the whole array
	logic [SFMF_DATA_W-1:0] dout_r, dout_nxt;
	logic oe_r, oe_nxt;

	// Staged word lands one write clock after capture, so the write side
	// trails the read side by a clock and chained units line up
	assign commit = wr_rise & stage_vld_r;

	// Write pointer and stage next values
	always_comb begin
		wr_ptr_nxt = wr_ptr_r;
		stage_vld_nxt = stage_vld_r;
		stage_addr_nxt = stage_addr_r;
		stage_data_nxt = stage_data_r;
		if (wr_rise) begin
			if (wr_pins.rst) begin
				// Enable and mask levels do not matter here
				wr_ptr_nxt = PTR_ZERO;
				stage_vld_nxt = 1'b0;
			end else if (wr_pins.en) begin
				// Pointer moves even when the mask blocks the store
				stage_vld_nxt = wr_pins.mask;
				stage_addr_nxt = wr_ptr_r;
				stage_data_nxt = wr_pins.data;
				wr_ptr_nxt = wr_ptr_r + PTR_ONE;
			end else begin
				// Nothing captured, pointer held as long as needed
				stage_vld_nxt = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			wr_ptr_r <= PTR_ZERO;
			stage_vld_r <= 1'b0;
			stage_addr_r <= PTR_ZERO;
			stage_data_r <= SFMF_DATA_ZERO;
		end else begin
			wr_ptr_r <= wr_ptr_nxt;
			stage_vld_r <= stage_vld_nxt;
			stage_addr_r <= stage_addr_nxt;
			stage_data_r <= stage_data_nxt;
		end
	end

	// Array write; contents survive any pause of either port clock
	always_ff @(posedge clk_i) begin
		if (commit) begin
			mem_r[stage_addr_r] <= stage_data_r;
		end
	end

	// Read pointer, output word and driver enable next values
	always_comb begin
		rd_ptr_nxt = rd_ptr_r;
		dout_nxt = dout_r;
		oe_nxt = oe_r;
		if (rd_rise) begin
			if (rd_pins.rst) begin
				// Enable and output enable are ignored here
				rd_ptr_nxt = PTR_ZERO;
			end else begin
				oe_nxt = rd_pins.oe;
				if (rd_pins.en) begin
					// Word zero comes on the first enabled edge
					dout_nxt = mem_r[rd_ptr_r];
					// Pointer moves whatever the driver enable says
					rd_ptr_nxt = rd_ptr_r + PTR_ONE;
				end
				// Enable low: pointer and word stay put
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			rd_ptr_r <= PTR_ZERO;
			dout_r <= SFMF_DATA_ZERO;
			oe_r <= 1'b0;
		end else begin
			rd_ptr_r <= rd_ptr_nxt;
			dout_r <= dout_nxt;
			oe_r <= oe_nxt;
		end
	end

	// Tri-state driver is resolved outside; data keeps write polarity
	assign read_data_bus_o = dout_r;
	assign read_data_bus_oe_o = oe_r;
endmodule

// *** testbench/sfmf_properties.sv ***
`timescale 1ns/10ps
// Read side output checks; write side has no outputs to watch
module sfmf_checker (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic read_port_clock_i,
	input wire logic read_pointer_reset_i,
	input wire logic read_advance_enable_i,
	input wire logic output_enable_i,
	input wire logic [sfmf_pkg::SFMF_DATA_W-1:0] read_data_bus_o,
	input wire logic read_data_bus_oe_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	// Pins that qualify a rise are sampled four edges before the answer
	a_reset_quiet: assert property ($rose(reset_n_i) |->
		read_data_bus_o == 8'h00 && !read_data_bus_oe_o)
		else $error("outputs not idle after reset");
	a_data_on_rise: assert property ($changed(read_data_bus_o) |->
		$past(read_port_clock_i, 2))
		else $error("data moved without a read clock rise");
	a_data_clock_stop: assert property (!read_port_clock_i [*6] |->
		$stable(read_data_bus_o))
		else $error("data moved while read clock stood");
	a_oe_clock_stop: assert property (!read_port_clock_i [*6] |->
		$stable(read_data_bus_oe_o))
		else $error("driver enable moved while read clock stood");
	a_rst_data_held: assert property ($changed(read_data_bus_o) |->
		!$past(read_pointer_reset_i, 5))
		else $error("data moved on a read reset rise");
	a_rst_oe_held: assert property ($changed(read_data_bus_oe_o) |->
		!$past(read_pointer_reset_i, 5))
		else $error("driver enable moved on a read reset rise");
	a_enable_low_hold: assert property ($changed(read_data_bus_o) |->
		$past(read_advance_enable_i, 5))
		else $error("data moved with read enable low");
	a_oe_follows_pin: assert property ($changed(read_data_bus_oe_o) |->
		read_data_bus_oe_o == $past(output_enable_i, 5))
		else $error("driver enable differs from its pin");
	c_data_moves: cover property ($changed(read_data_bus_o));
	c_oe_rise: cover property ($rose(read_data_bus_oe_o));
	c_oe_fall: cover property ($fell(read_data_bus_oe_o));
endmodule
bind sfmf_top sfmf_checker u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
	.read_port_clock_i(read_port_clock_i),
	.read_pointer_reset_i(read_pointer_reset_i),
	.read_advance_enable_i(read_advance_enable_i),
	.output_enable_i(output_enable_i), .read_data_bus_o(read_data_bus_o),
	.read_data_bus_oe_o(read_data_bus_oe_o));

// *** testbench/sfmf_port_model.sv ***
`timescale 1ns/10ps
// Video logic driving both ports; each port clock idles low between calls
module sfmf_port_model (
	input wire logic clk_i,
	output sfmf_pkg::sfmf_wr_pins_t wr_o,
	output logic wck_o,
	output sfmf_pkg::sfmf_rd_pins_t rd_o,
	output logic rck_o
);
	initial begin
		wr_o = '0;
		rd_o = '0;
		wck_o = 1'b0;
		rck_o = 1'b0;
	end
	// Pins settle four clk_i edges before the rise, so slow sync is safe
	task automatic wr(input logic r, e, m, input logic [7:0] d);
		@(posedge clk_i) wr_o <= {r, e, m, d};
		repeat (4) @(posedge clk_i);
		wck_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		wck_o <= 1'b0;
	endtask
	// Returns two edges after the fall, when the answer has landed
	task automatic rd(input logic r, e, o);
		@(posedge clk_i) rd_o <= {r, e, o};
		repeat (4) @(posedge clk_i);
		rck_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		rck_o <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask
endmodule

// *** testbench/test_serial_field_memory_fifo.sv ***
`timescale 1ns/10ps
module test_serial_field_memory_fifo;
	import sfmf_pkg::*;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	sfmf_wr_pins_t wp;
	sfmf_rd_pins_t rp;
	logic wck;
	logic rck;
	logic [SFMF_DATA_W-1:0] dq;
	logic oe;
	int err_count = 0;
	int check_count = 0;
	int cyc = 0;
	always #2 clk_i = ~clk_i;
	sfmf_port_model p (.clk_i(clk_i), .wr_o(wp), .wck_o(wck), .rd_o(rp),
		.rck_o(rck));
	// Small depth keeps the run short
	sfmf_top #(.ADDR_W(8)) dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.write_port_clock_i(wck), .write_pointer_reset_i(wp.rst),
		.write_enable_i(wp.en), .input_mask_i(wp.mask),
		.write_data_bus_i(wp.data), .read_port_clock_i(rck),
		.read_pointer_reset_i(rp.rst), .read_advance_enable_i(rp.en),
		.output_enable_i(rp.oe), .read_data_bus_o(dq),
		.read_data_bus_oe_o(oe));
	function automatic logic [7:0] pat(input int k);
		return 8'(k * 3 + 1);
	endfunction
	task automatic check(input string n, input logic [7:0] s, x);
		check_count++;
		if (s !== x) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic summarize;
		$display("errors %0d checks %0d", err_count, check_count);
		if (err_count == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Dummy cycles write zeros to the first 80 places; reads stay disabled
	// so the output never shows storage that holds no word yet
	task automatic power_up;
		for (int i = 0; i < 80; i++) begin
			p.wr(1'b0, 1'b1, 1'b1, 8'h00);
			p.rd(1'b0, 1'b0, 1'b0);
		end
	endtask
	// Idle write clocks keep written data apart from its read back
	task automatic let_settle;
		for (int i = 0; i < 600; i++) begin
			p.wr(1'b0, 1'b0, 1'b0, 8'h00);
		end
	endtask
	// Skipped store at 5, stalled cycle at 10, flush by reset carrying junk
	task automatic write_field;
		p.wr(1'b1, 1'b0, 1'b0, 8'h00);
		for (int k = 0; k < 80; k++) begin
			if (k == 10) p.wr(1'b0, 1'b0, 1'b1, 8'hee);
			p.wr(1'b0, 1'b1, k != 5, pat(k));
		end
		p.wr(1'b1, 1'b1, 1'b1, 8'hff);
		p.wr(1'b0, 1'b0, 1'b0, 8'h00);
		p.wr(1'b0, 1'b0, 1'b0, 8'h00);
	endtask
	// Drivers off at 20, stalled cycle before 30
	task automatic read_field(input logic oe_was);
		p.rd(1'b1, 1'b1, 1'b1);
		check("oe after reset", {7'h00, oe}, {7'h00, oe_was});
		for (int k = 0; k < 80; k++) begin
			if (k == 30) begin
				p.rd(1'b0, 1'b0, 1'b1);
				check("held word", dq, pat(29));
			end
			p.rd(1'b0, 1'b1, k != 20);
			check("oe", {7'h00, oe}, {7'h00, k != 20});
			if (k != 20) check("word", dq, k == 5 ? 8'h00 : pat(k));
		end
	endtask
	// Cycle ceiling well above the expected run
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_count++;
			summarize();
		end
	end
	initial begin
		repeat (2) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		power_up();
		write_field();
		let_settle();
		read_field(1'b0);
		read_field(1'b1);
		summarize();
	end
endmodule
